// ### core/rrc_consts.svh
// Constants for the rack receiver command-byte decoder.
// Included by the package and by the design modules; guarded.
`ifndef RRC_CONSTS_SVH
`define RRC_CONSTS_SVH

// Command byte bit positions
`define RRC_CMD_FORCE_RST 0
`define RRC_CMD_CLR_LATCH 1
`define RRC_CMD_USER_LAMP 2
`define RRC_CMD_DIAG_EN 3
`define RRC_CMD_RST_MASK 4
`define RRC_CMD_IN_BLOCK 5
`define RRC_CMD_BP_MASK 6
`define RRC_CMD_DN_MASK 7
`define RRC_CMD_RESET_VAL 8'h00

// Diagnostic byte layout
`define RRC_NFAULT 6
`define RRC_FLT_CHAIN_BP 0
`define RRC_FLT_CHAIN_DN 1
`define RRC_FLT_PSU 2
`define RRC_FLT_IN_PAR 3
`define RRC_FLT_WDOG 4
`define RRC_FLT_OUT_PAR 5

// Synchroniser vector layout
`define RRC_SYNC_W 19
`define RRC_S_WR 8
`define RRC_S_ACCESS 9
`define RRC_S_POLL 10
`define RRC_S_CPU_RST 11
`define RRC_S_CHAIN_BP 12
`define RRC_S_CHAIN_DN 13
`define RRC_S_PSU 14
`define RRC_S_IN_PAR 15
`define RRC_S_OUT_PAR 16
`define RRC_S_STRAP 17
`define RRC_S_WD_BLOCK 18

// Timing
`define RRC_CLK_MHZ 50
`define RRC_TICK_US 1000
`define RRC_WD_TIME_MS 1000
`define RRC_TICK_CYCLES (`RRC_CLK_MHZ * `RRC_TICK_US)
`define RRC_WD_TICKS (`RRC_WD_TIME_MS * 1000 / `RRC_TICK_US)

`endif

// ### core/rrc_pkg.sv
// Types for the rack receiver command-byte decoder.
// Needs rrc_consts.svh on the include path.
package rrc_pkg;
  `include "rrc_consts.svh"

  typedef enum logic {WD_RUN, WD_EXPIRED} rrc_wd_mode_t;

  typedef struct packed {
    rrc_wd_mode_t mode;
    logic [15:0] pre;
    logic [15:0] ticks;
    logic fire;
  } rrc_wd_state_t;

  typedef struct packed {
    logic [`RRC_SYNC_W-1:0] s1;
    logic [`RRC_SYNC_W-1:0] s2;
    logic [`RRC_SYNC_W-1:0] s3;
    logic [7:0] cmd;
    logic [`RRC_NFAULT-1:0] latch;
    logic rack_rst;
    logic rst_pass;
    logic [7:0] diag;
    logic diag_oe;
    logic in_block;
    logic chain_up;
  } rrc_state_t;
endpackage

// ### core/rrc_wd_if.sv
// Link between the decoder and its watchdog.
// Both ends share clk_i.
`timescale 1ns/1ps
interface rrc_wd_if;
  logic kick;
  logic expired;
  logic fire;
  modport wd (input kick, output expired, output fire);
  modport ctrl (output kick, input expired, input fire);
endinterface

// ### core/rrc_watchdog.sv
// Channel watchdog: restarts on each access, fires once on timeout.
// Kick is a one-cycle pulse on clk_i.
`timescale 1ns/1ps
`include "rrc_consts.svh"
module rrc_watchdog
  import rrc_pkg::*;
#(
  parameter int TICK_CYCLES = `RRC_TICK_CYCLES,
  parameter int WD_TICKS = `RRC_WD_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  rrc_wd_if.wd w
);
  rrc_wd_state_t q, n;

  always_comb begin
    n = q;
    n.fire = 1'b0;
    if (w.kick) begin
      n.mode = WD_RUN;
      n.pre = 16'h0000;
      n.ticks = 16'h0000;
    end else if (q.mode == WD_RUN) begin
      // Prescaler keeps the counters narrow
      if (q.pre == 16'(TICK_CYCLES - 1)) begin
        n.pre = 16'h0000;
        if (q.ticks == 16'(WD_TICKS - 1)) begin
          n.mode = WD_EXPIRED;
          n.fire = 1'b1;
          n.ticks = 16'h0000;
        end else begin
          n.ticks = q.ticks + 16'h0001;
        end
      end else begin
        n.pre = q.pre + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign w.expired = (q.mode == WD_EXPIRED);
  assign w.fire = q.fire;
endmodule // rrc_watchdog

// ### core/rrc_ctrl.sv
// Command-byte decoder of a rack I/O receiver.
// All chain and switch inputs are asynchronous; data must be stable
// around the command write strobe.
//
// Contract
// - Command bit 1 set forces rack reset until it clears.
// - Hold-last-state output modules ignore that forced reset.
// - Command bit 2 clears all six fault latches and their lamps.
// - Latch clear fires only on rising edge of bit 2.
// - User lamp lit while bit 3 is zero, dark when one.
// - Diagnostic byte answered to polls only while bit 4 is one.
// - Bit 5 zero: CPU reset broadcast resets rack outputs.
// - Bit 5 one: CPU reset broadcast ignored in this rack.
// - CPU reset always passed downstream regardless of bit 5.
// - Masked CPU reset: outputs hold until one-second watchdog reset.
// - Watchdog block switch closed suppresses the watchdog reset.
// - Bit 6 one blocks rack input data from the CPU.
// - Bit 7 one blocks backplane chain faults going upstream.
// - Bit 8 one blocks downstream chain faults going upstream.
// - One-second watchdog restarts on access, sets diagnostic bit 5.
// - Command and diagnostic bytes are eight bits, bit 1 least.
`timescale 1ns/1ps
`include "rrc_consts.svh"
module rrc_ctrl
  import rrc_pkg::*;
#(
  parameter int TICK_CYCLES = `RRC_TICK_CYCLES,
  parameter int WD_TICKS = `RRC_WD_TICKS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic chan_access_i,
  input wire logic diag_poll_i,
  input wire logic cpu_rst_i,
  input wire logic chain_bp_i,
  input wire logic chain_dn_i,
  input wire logic psu_fault_i,
  input wire logic in_par_i,
  input wire logic out_par_i,
  input wire logic inter_rack_i,
  input wire logic wd_block_i,
  output logic rack_rst_o,
  output logic rst_pass_o,
  output logic [`RRC_NFAULT-1:0] lamp_off_o,
  output logic user_lamp_off_o,
  output logic [7:0] diag_data_o,
  output logic diag_oe_o,
  output logic in_block_o,
  output logic chain_fault_up_o
);
  rrc_state_t q, n;
  rrc_wd_if wdl ();
  logic [`RRC_SYNC_W-1:0] raw;
  logic [`RRC_SYNC_W-1:0] rise;
  logic [`RRC_NFAULT-1:0] ev;
  logic clr;

  assign raw = {wd_block_i, inter_rack_i, out_par_i, in_par_i, psu_fault_i, chain_dn_i,
                chain_bp_i, cpu_rst_i, diag_poll_i, chan_access_i, cmd_wr_i, cmd_data_i};

  // Edges only from the second and third stages
  genvar gi;
  generate
    for (gi = 0; gi < `RRC_SYNC_W; gi = gi + 1) begin : g_edge
      assign rise[gi] = q.s2[gi] & ~q.s3[gi];
    end
  endgenerate

  // Faults set their latch on onset, so a clear works under a standing fault
  assign ev[`RRC_FLT_CHAIN_BP] = rise[`RRC_S_CHAIN_BP];
  assign ev[`RRC_FLT_CHAIN_DN] = rise[`RRC_S_CHAIN_DN];
  assign ev[`RRC_FLT_PSU] = rise[`RRC_S_PSU];
  assign ev[`RRC_FLT_IN_PAR] = rise[`RRC_S_IN_PAR];
  assign ev[`RRC_FLT_WDOG] = wdl.fire;
  assign ev[`RRC_FLT_OUT_PAR] = rise[`RRC_S_OUT_PAR];

  assign wdl.kick = rise[`RRC_S_ACCESS];

  rrc_watchdog #(
    .TICK_CYCLES(TICK_CYCLES),
    .WD_TICKS(WD_TICKS)
  ) u_wd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .w(wdl.wd)
  );

  always_comb begin
    n = q;
    n.s1 = raw;
    n.s2 = q.s1;
    n.s3 = q.s2;
    if (rise[`RRC_S_WR]) begin
      n.cmd = q.s2[7:0];
    end
    clr = n.cmd[`RRC_CMD_CLR_LATCH] & ~q.cmd[`RRC_CMD_CLR_LATCH];
    for (int i = 0; i < `RRC_NFAULT; i++) begin
      // A new fault in the clear cycle wins
      n.latch[i] = ev[i] | (q.latch[i] & ~clr);
    end
    // Hold-last-state modules decode this themselves and stay put
    n.rack_rst = q.cmd[`RRC_CMD_FORCE_RST]
               | (q.s2[`RRC_S_CPU_RST] & ~q.cmd[`RRC_CMD_RST_MASK])
               | (wdl.expired & ~q.s2[`RRC_S_WD_BLOCK]);
    n.rst_pass = q.s2[`RRC_S_CPU_RST];
    n.diag_oe = q.s2[`RRC_S_POLL] & q.cmd[`RRC_CMD_DIAG_EN];
    n.diag = n.diag_oe ? {1'b1, q.s2[`RRC_S_STRAP], q.latch} : 8'h00;
    n.in_block = q.cmd[`RRC_CMD_IN_BLOCK];
    n.chain_up = (q.s2[`RRC_S_CHAIN_BP] & ~q.cmd[`RRC_CMD_BP_MASK])
               | (q.s2[`RRC_S_CHAIN_DN] & ~q.cmd[`RRC_CMD_DN_MASK]);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.cmd <= `RRC_CMD_RESET_VAL;
    end else begin
      q <= n;
    end
  end

  assign rack_rst_o = q.rack_rst;
  assign rst_pass_o = q.rst_pass;
  assign lamp_off_o = q.latch;
  assign user_lamp_off_o = q.cmd[`RRC_CMD_USER_LAMP];
  assign diag_data_o = q.diag;
  assign diag_oe_o = q.diag_oe;
  assign in_block_o = q.in_block;
  assign chain_fault_up_o = q.chain_up;
endmodule // rrc_ctrl

// ### dv/rrc_ctrl_props.sv
// Port checker for the command-byte decoder.
// Bound to rrc_ctrl; sees its ports only, inputs held low in reset.
`timescale 1ns/1ps
module rrc_ctrl_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_wr_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic diag_poll_i,
  input wire logic cpu_rst_i,
  input wire logic chain_bp_i,
  input wire logic chain_dn_i,
  input wire logic rack_rst_o,
  input wire logic rst_pass_o,
  input wire logic user_lamp_off_o,
  input wire logic [7:0] diag_data_o,
  input wire logic diag_oe_o,
  input wire logic in_block_o,
  input wire logic chain_fault_up_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_pass; cpu_rst_i |-> ##3 rst_pass_o; endproperty
  a_pass: assert property (p_pass) else $error("reset not passed on");
  property p_frst; $rose(cmd_wr_i) && cmd_data_i[0] |-> ##4 rack_rst_o; endproperty
  a_frst: assert property (p_frst) else $error("forced reset missing");
  property p_lamp;
    $rose(cmd_wr_i) |-> ##3 user_lamp_off_o == $past(cmd_data_i[2], 3);
  endproperty
  a_lamp: assert property (p_lamp) else $error("user lamp wrong");
  property p_blk; $rose(cmd_wr_i) |-> ##4 in_block_o == $past(cmd_data_i[5], 4); endproperty
  a_blk: assert property (p_blk) else $error("input block wrong");
  property p_hold; !cmd_wr_i [*4] |-> $stable(user_lamp_off_o); endproperty
  a_hold: assert property (p_hold) else $error("lamp moved without write");
  property p_oe; diag_oe_o |-> diag_data_o[7] && $past(diag_poll_i, 3); endproperty
  a_oe: assert property (p_oe) else $error("diag answer without poll");
  property p_off; !diag_oe_o |-> diag_data_o == 8'h00; endproperty
  a_off: assert property (p_off) else $error("diag data while idle");
  property p_chain; chain_fault_up_o |-> $past(chain_bp_i || chain_dn_i, 3); endproperty
  a_chain: assert property (p_chain) else $error("chain fault without cause");
endmodule // rrc_ctrl_props
bind rrc_ctrl rrc_ctrl_props u_props (.*);

// ### dv/rrc_cpu_model.sv
// CPU side: writes the command byte, polls, drives the reset broadcast.
// Changes lines 1 ns after a rising edge of clk_i.
`timescale 1ns/1ps
module rrc_cpu_model (
  input wire logic clk_i,
  output logic wr_o,
  output logic [7:0] data_o,
  output logic access_o,
  output logic poll_o,
  output logic rst_o
);
  initial begin
    wr_o = 1'b0;
    data_o = 8'h00;
    poll_o = 1'b0;
    rst_o = 1'b0;
  end
  assign access_o = wr_o | poll_o;
  // One command address per receiver; data held around the strobe
  task automatic write_cmd(input logic [7:0] d);
    @(posedge clk_i);
    #1 data_o = d;
    repeat (3) @(posedge clk_i);
    #1 wr_o = 1'b1;
    repeat (3) @(posedge clk_i);
    #1 wr_o = 1'b0;
    repeat (3) @(posedge clk_i);
    #1 data_o = ~d;
  endtask
  task automatic set_lines(input logic p, input logic r);
    @(posedge clk_i);
    #1 poll_o = p;
    rst_o = r;
    repeat (4) @(posedge clk_i);
    #1;
  endtask
endmodule // rrc_cpu_model

// ### dv/tb_rrc_ctrl.sv
// Self-checking bench for the command-byte decoder.
// Watchdog shortened to 200 clocks; strap driven high, later low.
`timescale 1ns/1ps
module tb_rrc_ctrl;
  logic clk_i;
  logic rst_i;
  logic bp, dn, psu, ipar, opar, wdb, strap;
  logic wr, acc, poll, crst, rrst, pass, ulamp, oe, inblk, cup;
  logic [7:0] data, diag;
  logic [5:0] lamps;
  int err_total = 0;
  int num_checks = 0;
  always #10 clk_i = ~clk_i;
  rrc_cpu_model u_cpu (.clk_i(clk_i), .wr_o(wr), .data_o(data), .access_o(acc),
    .poll_o(poll), .rst_o(crst));
  rrc_ctrl #(.TICK_CYCLES(20), .WD_TICKS(10)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .cmd_wr_i(wr), .cmd_data_i(data), .chan_access_i(acc), .diag_poll_i(poll),
    .cpu_rst_i(crst), .chain_bp_i(bp), .chain_dn_i(dn), .psu_fault_i(psu), .in_par_i(ipar),
    .out_par_i(opar), .inter_rack_i(strap), .wd_block_i(wdb), .rack_rst_o(rrst),
    .rst_pass_o(pass), .lamp_off_o(lamps), .user_lamp_off_o(ulamp), .diag_data_o(diag),
    .diag_oe_o(oe), .in_block_o(inblk), .chain_fault_up_o(cup));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {bp, dn, psu, ipar, opar, wdb, strap} = 7'h01;
    repeat (6) @(posedge clk_i);
    #1 rst_i = 1'b0;
    chk({rrst, ulamp, inblk, oe, lamps[3:0]}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      u_cpu.write_cmd(8'h01 << i);
      chk({5'h00, rrst, ulamp, inblk}, {5'h00, i == 0, i == 2, i == 5});
    end
    u_cpu.write_cmd(8'h00);
    u_cpu.set_lines(1'b0, 1'b1);
    chk({6'h00, rrst, pass}, 8'h03);
    u_cpu.write_cmd(8'h10);
    chk({6'h00, rrst, pass}, 8'h01);
    u_cpu.set_lines(1'b0, 1'b0);
    {psu, ipar, opar} = 3'b111;
    u_cpu.write_cmd(8'h00);
    chk({2'b00, lamps}, 8'h2c);
    u_cpu.write_cmd(8'h0a);
    chk({2'b00, lamps}, 8'h00);
    psu = 1'b0;
    repeat (4) @(posedge clk_i);
    #1 psu = 1'b1;
    u_cpu.write_cmd(8'h0e);
    chk({2'b00, lamps}, 8'h04);
    u_cpu.set_lines(1'b1, 1'b0);
    chk({7'h00, oe}, 8'h01);
    chk(diag, 8'hc4);
    strap = 1'b0;
    repeat (3) @(posedge clk_i);
    #1 chk(diag, 8'h84);
    u_cpu.write_cmd(8'h06);
    chk({7'h00, oe}, 8'h00);
    u_cpu.set_lines(1'b0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      {bp, dn} = k[1] ? 2'b01 : 2'b10;
      u_cpu.write_cmd(k[0] ? (k[1] ? 8'h80 : 8'h40) : 8'h00);
      chk({7'h00, cup}, {7'h00, !k[0]});
    end
    u_cpu.write_cmd(8'h10);
    u_cpu.set_lines(1'b0, 1'b1);
    chk({7'h00, rrst}, 8'h00);
    repeat (220) @(posedge clk_i);
    #1 chk({6'h00, rrst, lamps[4]}, 8'h03);
    wdb = 1'b1;
    u_cpu.write_cmd(8'h10);
    repeat (220) @(posedge clk_i);
    #1 chk({7'h00, rrst}, 8'h00);
    u_cpu.set_lines(1'b0, 1'b0);
    u_cpu.write_cmd(8'h25);
    chk({5'h00, rrst, ulamp, inblk}, 8'h07);
    // Mid-run power cycle must drop the whole command byte
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1 chk({5'h00, rrst, ulamp, inblk}, 8'h00);
    print_verdict;
  end
  // Cuts a hang well past the expected run of under 1000 clocks
  initial begin
    #100000;
    err_total++;
    print_verdict;
  end
endmodule // tb_rrc_ctrl
